// >>> cprx_status_debug.sv
// content-protection status mirror, key list read port and debug control
// assumes link side inputs are synchronous to clk_i
//
// Behaviour
// - transmitter key bytes 2..4 read-only at 0x92..0x94.
// - repeater flag bit 6 valid only once receiver key is ready.
// - capability bit 5 shows receiver key list and check value done.
// - capability bit 4 fast bus is shown but never used.
// - capability bit 1 shows enhanced signalling, cipher, link check support.
// - capability bit 0 shows receiver takes clear video during reauth.
// - topology bit 7 flags device count beyond key list depth.
// - topology bits 6:0 give device count, zero for non-repeater.
// - second topology bit 3 flags more than seven cascaded levels.
// - second topology bits 2:0 give cascade depth below repeater.
// - each key list port read of a non-empty list returns next byte and advances, unless a clear in the same cycle resets the list; an empty list reads zero.
// - bus counts as free after more than one second idle.
// - debug bit 6 set turns the bus idle timeout off.
// - integrity checked at frame 128, sync check one frame before at 127.
// - debug bit 4 suppresses only the sync check, in both normal and test mode.
// - debug bit 3 sends ones-complement channel sums after each line.
// - test mode: verification every 2 frames, integrity every 16.
// - normal mode: verification every 16 frames, integrity every 128.
// - debug bit 1 shortens authentication timers.
// - debug bit 0 picks fast bus timing, mirrored in indirect status.
// - receiver key bytes 0..4 read-only from 0x80.
`default_nettype none

`include "cprx_cfg.svh"

module cprx_status_debug #(
  parameter int TIMEOUT_CYC = `CPRX_BUS_TIMEOUT_S * `CPRX_CLK_HZ
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire cprx_pkg::cprx_reg_req_t reg_req_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [39:0] tx_key_i,
  input wire logic [39:0] rx_key_i,
  input wire cprx_pkg::cprx_rx_status_t rx_status_i,
  input wire logic key_list_clear_i,
  input wire logic key_list_wr_i,
  input wire logic [7:0] key_list_byte_i,
  input wire logic bus_activity_i,
  output logic bus_free_o,
  input wire logic frame_start_i,
  output logic pj_check_o,
  output logic ri_check_o,
  output logic ri_sync_check_o,
  input wire cprx_pkg::cprx_pixel_t pixel_i,
  output logic line_checksum_valid_o,
  output logic [23:0] line_checksum_o,
  output logic auth_timer_accelerate_o,
  output logic bus_master_fast_timing_o,
  output logic indirect_status_fast_o
);
  import cprx_pkg::*;

  // =========================================================
  // state
  // =========================================================
  cprx_state_t st_ff;
  cprx_state_t nxt_st;
  logic [7:0] list_mem [`CPRX_LIST_DEPTH];
  logic [7:0] rd_mux;
  logic list_empty;
  logic list_full;
  logic list_rd;
  logic [6:0] fc_next;
  logic [7:0] pj_per;
  logic [7:0] ri_per;
  logic [6:0] pj_mask;
  logic [6:0] ri_mask;
  logic [2:0][7:0] sum_add;

  // free only once idle for more than the full timeout
  localparam logic [`CPRX_IDLE_W-1:0] TO_LAST =
    `CPRX_IDLE_W'(TIMEOUT_CYC);
  localparam logic [`CPRX_LIST_AW-1:0] LIST_LAST =
    `CPRX_LIST_AW'(`CPRX_LIST_DEPTH - 1);

  assign list_empty = (st_ff.rptr == st_ff.wptr);
  assign list_full = (st_ff.wptr == LIST_LAST);
  assign list_rd = reg_req_i.rd && reg_req_i.addr == `CPRX_OFS_KEY_LIST &&
    !list_empty;

  // =========================================================
  // key list storage
  // =========================================================
  always_ff @(posedge clk_i)
  begin
    if (key_list_wr_i && !key_list_clear_i && !list_full)
    begin
      list_mem[st_ff.wptr] <= key_list_byte_i;
    end
  end

  // =========================================================
  // read decode
  // =========================================================
  always_comb
  begin
    rd_mux = 8'h00;
    case (reg_req_i.addr)
      `CPRX_OFS_TX_KEY2: rd_mux = tx_key_i[23:16];
      `CPRX_OFS_TX_KEY3: rd_mux = tx_key_i[31:24];
      `CPRX_OFS_TX_KEY4: rd_mux = tx_key_i[39:32];
      `CPRX_OFS_CAPS:
      begin
        // repeater only reported once the receiver key is in
        rd_mux[`CPRX_CAP_REPEATER] = rx_status_i.repeater &&
          rx_status_i.key_ready;
        rd_mux[`CPRX_CAP_LIST_RDY] = rx_status_i.key_list_ready;
        rd_mux[`CPRX_CAP_FAST_BUS] = rx_status_i.fast_bus;
        rd_mux[`CPRX_CAP_ENH] = rx_status_i.enhanced;
        rd_mux[`CPRX_CAP_QUICK] =
          rx_status_i.receiver_quick_reauthentication;
      end
      `CPRX_OFS_TOPO_LO:
      begin
        rd_mux[`CPRX_TOPO_DEV_ERR] = rx_status_i.device_limit_error;
        rd_mux[6:0] = rx_status_i.repeater ?
          rx_status_i.device_count : 7'h00;
      end
      `CPRX_OFS_TOPO_HI:
      begin
        rd_mux[`CPRX_TOPO_CASC_ERR] = rx_status_i.cascade_limit_error;
        rd_mux[2:0] = rx_status_i.cascade_depth;
      end
      `CPRX_OFS_KEY_LIST: rd_mux = list_empty ? 8'h00 :
        list_mem[st_ff.rptr];
      `CPRX_OFS_DEBUG: rd_mux = st_ff.dbg & `CPRX_DBG_WMASK;
      default:
      begin
        if (reg_req_i.addr >= `CPRX_OFS_RX_KEY0 &&
            reg_req_i.addr <= `CPRX_OFS_RX_KEY4)
        begin
          rd_mux = rx_key_i[{reg_req_i.addr[2:0], 3'h0} +: 8];
        end
      end
    endcase
  end

  // =========================================================
  // per-channel ones-complement adders
  // =========================================================
  genvar ch;
  generate
    for (ch = 0; ch < 3; ch++)
    begin : g_chan
      logic [8:0] raw;
      assign raw = {1'b0, st_ff.sum[ch]} + {1'b0, pixel_i.data[ch]};
      // end-around carry keeps the sum in ones complement
      assign sum_add[ch] = raw[7:0] + {7'h00, raw[8]};
    end
  endgenerate

  // =========================================================
  // next state
  // =========================================================
  assign pj_per = st_ff.dbg[`CPRX_DBG_FC_TEST] ?
    `CPRX_PJ_PERIOD_TEST : `CPRX_PJ_PERIOD;
  assign ri_per = st_ff.dbg[`CPRX_DBG_FC_TEST] ?
    `CPRX_RI_PERIOD_TEST : `CPRX_RI_PERIOD;
  // a period of 128 wraps to the all-ones mask of the 7 bit counter
  assign pj_mask = pj_per[6:0] - 7'd1;
  assign ri_mask = ri_per[6:0] - 7'd1;
  assign fc_next = st_ff.frame_cnt + 7'd1;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.rdata = reg_req_i.rd ? rd_mux : 8'h00;
    if (reg_req_i.wr && reg_req_i.addr == `CPRX_OFS_DEBUG)
    begin
      nxt_st.dbg = reg_req_i.wdata & `CPRX_DBG_WMASK;
    end

    // key list pointers
    if (key_list_clear_i)
    begin
      nxt_st.rptr = '0;
      nxt_st.wptr = '0;
    end
    else
    begin
      if (list_rd)
      begin
        nxt_st.rptr = st_ff.rptr + `CPRX_LIST_AW'(1);
      end
      if (key_list_wr_i && !list_full)
      begin
        nxt_st.wptr = st_ff.wptr + `CPRX_LIST_AW'(1);
      end
    end

    // bus idle watchdog
    if (st_ff.dbg[`CPRX_DBG_TO_DIS] || bus_activity_i)
    begin
      nxt_st.idle_cnt = '0;
      nxt_st.bus_free = 1'b0;
    end
    else if (st_ff.idle_cnt == TO_LAST)
    begin
      nxt_st.bus_free = 1'b1;
    end
    else
    begin
      nxt_st.idle_cnt = st_ff.idle_cnt + `CPRX_IDLE_W'(1);
    end

    // frame counter driven checks
    nxt_st.pj_pulse = 1'b0;
    nxt_st.ri_pulse = 1'b0;
    nxt_st.sync_pulse = 1'b0;
    if (frame_start_i)
    begin
      nxt_st.frame_cnt = fc_next;
      nxt_st.pj_pulse = (fc_next & pj_mask) == 7'd0;
      nxt_st.ri_pulse = (fc_next & ri_mask) == 7'd0;
      nxt_st.sync_pulse = ((fc_next & ri_mask) == ri_mask) &&
        !st_ff.dbg[`CPRX_DBG_SYNC_DIS];
    end

    // line checksums
    nxt_st.cks_valid = 1'b0;
    if (pixel_i.valid)
    begin
      nxt_st.sum = sum_add;
    end
    if (pixel_i.end_of_line)
    begin
      nxt_st.sum = '0;
      if (st_ff.dbg[`CPRX_DBG_CKS_EN])
      begin
        nxt_st.cks_valid = 1'b1;
        nxt_st.cks = pixel_i.valid ? ~sum_add : ~st_ff.sum;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_ff <= '0;
      st_ff.dbg <= `CPRX_DBG_RESET;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // =========================================================
  // outputs
  // =========================================================
  assign reg_rdata_o = st_ff.rdata;
  assign bus_free_o = st_ff.bus_free;
  assign pj_check_o = st_ff.pj_pulse;
  assign ri_check_o = st_ff.ri_pulse;
  assign ri_sync_check_o = st_ff.sync_pulse;
  assign line_checksum_valid_o = st_ff.cks_valid;
  assign line_checksum_o = st_ff.cks;
  assign auth_timer_accelerate_o = st_ff.dbg[`CPRX_DBG_TMR_FAST];
  assign bus_master_fast_timing_o = st_ff.dbg[`CPRX_DBG_BUS_FAST];
  assign indirect_status_fast_o = st_ff.dbg[`CPRX_DBG_BUS_FAST];

  // =========================================================
  // checks
  // =========================================================
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_list_read;
    list_rd && !key_list_clear_i;
  endsequence

  sequence s_line_done;
    pixel_i.end_of_line && st_ff.dbg[`CPRX_DBG_CKS_EN];
  endsequence

  a_tx_key_read: assert property (
    reg_req_i.rd && reg_req_i.addr == `CPRX_OFS_TX_KEY3
    |=> reg_rdata_o == $past(tx_key_i[31:24]))
    else $error("tx key byte 3 read wrong");

  a_repeater_gated: assert property (
    reg_req_i.rd && reg_req_i.addr == `CPRX_OFS_CAPS &&
    !rx_status_i.key_ready |=> !reg_rdata_o[`CPRX_CAP_REPEATER])
    else $error("repeater shown before key ready");

  a_count_nonrep: assert property (
    reg_req_i.rd && reg_req_i.addr == `CPRX_OFS_TOPO_LO &&
    !rx_status_i.repeater |=> reg_rdata_o[6:0] == 7'h00)
    else $error("device count not zero for plain receiver");

  a_list_advance: assert property (
    s_list_read |=> st_ff.rptr == $past(st_ff.rptr) + `CPRX_LIST_AW'(1))
    else $error("key list read did not advance");

  a_list_empty_hold: assert property (
    reg_req_i.rd && reg_req_i.addr == `CPRX_OFS_KEY_LIST && list_empty &&
    !key_list_wr_i |=> reg_rdata_o == 8'h00 && list_empty)
    else $error("empty key list read moved or returned data");

  a_list_clear: assert property (
    key_list_clear_i |=> list_empty && st_ff.wptr == '0)
    else $error("key list not emptied by clear");

  a_rx_key_read: assert property (
    reg_req_i.rd && reg_req_i.addr == `CPRX_OFS_RX_KEY4
    |=> reg_rdata_o == $past(rx_key_i[39:32]))
    else $error("rx key byte 4 read wrong");

  a_device_limit: assert property (
    reg_req_i.rd && reg_req_i.addr == `CPRX_OFS_TOPO_LO
    |=> reg_rdata_o[7] == $past(rx_status_i.device_limit_error))
    else $error("device limit flag read wrong");

  a_unmapped_zero: assert property (
    reg_req_i.rd && reg_req_i.addr > `CPRX_OFS_KEY_LIST &&
    reg_req_i.addr < `CPRX_OFS_DEBUG
    |=> reg_rdata_o == 8'h00)
    else $error("unmapped read returned data");

  a_rdata_idle: assert property (
    !reg_req_i.rd |=> reg_rdata_o == 8'h00)
    else $error("read data shown without a read");

  a_bus_free_rise: assert property (
    $rose(bus_free_o) |-> $past(st_ff.idle_cnt) == TO_LAST &&
    !$past(bus_activity_i))
    else $error("bus freed before timeout");

  a_timeout_off: assert property (
    st_ff.dbg[`CPRX_DBG_TO_DIS] |=> !bus_free_o [*3])
    else $error("bus freed while timeout disabled");

  a_sync_check_off: assert property (
    st_ff.dbg[`CPRX_DBG_SYNC_DIS] && frame_start_i |=> !ri_sync_check_o)
    else $error("sync check ran while disabled");

  a_ri_period: assert property (
    ri_check_o && !$past(st_ff.dbg[`CPRX_DBG_FC_TEST])
    |-> st_ff.frame_cnt == 7'd0)
    else $error("integrity check off its 128 frame period");

  a_sync_slot: assert property (
    ri_sync_check_o && !$past(st_ff.dbg[`CPRX_DBG_FC_TEST])
    |-> st_ff.frame_cnt == 7'd127)
    else $error("sync check off frame 127");

  a_pj_test_period: assert property (
    pj_check_o && $past(st_ff.dbg[`CPRX_DBG_FC_TEST])
    |-> st_ff.frame_cnt[0] == 1'b0)
    else $error("verification check off its 2 frame period");

  a_line_checksum: assert property (
    s_line_done |=> line_checksum_valid_o)
    else $error("line checksum not sent");

  a_checksum_only: assert property (
    !(pixel_i.end_of_line && st_ff.dbg[`CPRX_DBG_CKS_EN])
    |=> !line_checksum_valid_o)
    else $error("line checksum sent without a line end");

  a_fast_mirror: assert property (
    reg_req_i.wr && reg_req_i.addr == `CPRX_OFS_DEBUG
    |=> bus_master_fast_timing_o == $past(reg_req_i.wdata[0]) &&
    indirect_status_fast_o == bus_master_fast_timing_o)
    else $error("fast timing not taken from debug write");

  a_reserved_zero: assert property (
    reg_req_i.rd && reg_req_i.addr == `CPRX_OFS_DEBUG
    |=> reg_rdata_o[7] == 1'b0 && reg_rdata_o[5] == 1'b0)
    else $error("reserved debug bits read non-zero");

endmodule

`default_nettype wire

// >>> cprx_cfg.svh
// constants of the content-protection status and debug register slice
// assumes an 8-bit register space reached over a plain strobe port
`ifndef CPRX_CFG_SVH
`define CPRX_CFG_SVH

// register offsets
`define CPRX_OFS_RX_KEY0 8'h80
`define CPRX_OFS_RX_KEY4 8'h84
`define CPRX_OFS_TX_KEY2 8'h92
`define CPRX_OFS_TX_KEY3 8'h93
`define CPRX_OFS_TX_KEY4 8'h94
`define CPRX_OFS_CAPS 8'ha0
`define CPRX_OFS_TOPO_LO 8'ha1
`define CPRX_OFS_TOPO_HI 8'ha2
`define CPRX_OFS_KEY_LIST 8'ha3
`define CPRX_OFS_DEBUG 8'hc0

// debug register fields
`define CPRX_DBG_RESET 8'h00
`define CPRX_DBG_WMASK 8'h5f
`define CPRX_DBG_TO_DIS 6
`define CPRX_DBG_SYNC_DIS 4
`define CPRX_DBG_CKS_EN 3
`define CPRX_DBG_FC_TEST 2
`define CPRX_DBG_TMR_FAST 1
`define CPRX_DBG_BUS_FAST 0

// capability and topology field positions
`define CPRX_CAP_REPEATER 6
`define CPRX_CAP_LIST_RDY 5
`define CPRX_CAP_FAST_BUS 4
`define CPRX_CAP_ENH 1
`define CPRX_CAP_QUICK 0
`define CPRX_TOPO_DEV_ERR 7
`define CPRX_TOPO_CASC_ERR 3

// key list storage: 128 devices of five bytes
`define CPRX_LIST_DEPTH 640
`define CPRX_LIST_AW 10

// frame periods
`define CPRX_PJ_PERIOD 8'd16
`define CPRX_PJ_PERIOD_TEST 8'd2
`define CPRX_RI_PERIOD 8'd128
`define CPRX_RI_PERIOD_TEST 8'd16

// bus idle timeout
`define CPRX_CLK_HZ 250000000
`define CPRX_BUS_TIMEOUT_S 1
`define CPRX_IDLE_W 28

`endif

// >>> cprx_pkg.sv
// types of the content-protection status and debug register slice
// assumes cprx_cfg.svh is on the include path
`default_nettype none

package cprx_pkg;
  `include "cprx_cfg.svh"

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cprx_reg_req_t;

  // capability and topology mirrored from the downstream receiver
  typedef struct packed {
    logic key_ready;
    logic repeater;
    logic key_list_ready;
    logic fast_bus;
    logic enhanced;
    logic receiver_quick_reauthentication;
    logic device_limit_error;
    logic [6:0] device_count;
    logic cascade_limit_error;
    logic [2:0] cascade_depth;
  } cprx_rx_status_t;

  typedef struct packed {
    logic valid;
    logic end_of_line;
    logic [2:0][7:0] data;
  } cprx_pixel_t;

  typedef struct packed {
    logic [7:0] rdata;
    logic [7:0] dbg;
    logic [`CPRX_LIST_AW-1:0] rptr;
    logic [`CPRX_LIST_AW-1:0] wptr;
    logic [`CPRX_IDLE_W-1:0] idle_cnt;
    logic bus_free;
    logic [6:0] frame_cnt;
    logic pj_pulse;
    logic ri_pulse;
    logic sync_pulse;
    logic [2:0][7:0] sum;
    logic cks_valid;
    logic [2:0][7:0] cks;
  } cprx_state_t;
endpackage

`default_nettype wire

// >>> cprx_rx_model.sv
// downstream receiver model: status levels, key vector and key list pushes
// assumes the bench changes its controls just after a rising edge
`default_nettype none

module cprx_rx_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic repeater_i,
  input wire logic key_ready_i,
  input wire logic push_i,
  input wire logic slow_i,
  input wire logic [7:0] base_i,
  output var cprx_pkg::cprx_rx_status_t rx_status_o,
  output logic [39:0] rx_key_o,
  output logic list_wr_o,
  output logic [7:0] list_byte_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import cprx_pkg::*;

  logic [3:0] left;
  logic phase;
  logic [7:0] next_byte;

  // ==========================================================
  // status and key vector
  assign rx_key_o = 40'h5a4b3c2d1e;
  assign rx_status_o = '{key_ready: key_ready_i, repeater: repeater_i,
    key_list_ready: 1'b1, fast_bus: 1'b1, enhanced: 1'b1,
    receiver_quick_reauthentication: 1'b1, device_limit_error: 1'b1,
    device_count: 7'h05, cascade_limit_error: 1'b1, cascade_depth: 3'h3};

  // ==========================================================
  // key list: three bytes per push, prompt or every other cycle
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      left <= 4'h0;
      phase <= 1'b0;
      list_wr_o <= 1'b0;
      list_byte_o <= 8'h00;
      next_byte <= 8'h00;
    end
    else
    begin
      phase <= ~phase;
      list_wr_o <= 1'b0;
      // idle data line toggles, never holds the last byte
      list_byte_o <= ~list_byte_o;
      if (push_i)
      begin
        left <= 4'h3;
        next_byte <= base_i;
      end
      else if (left != 4'h0 && (!slow_i || phase))
      begin
        list_wr_o <= 1'b1;
        list_byte_o <= next_byte;
        next_byte <= next_byte + 8'h01;
        left <= left - 4'h1;
      end
    end
  end
endmodule

`default_nettype wire

// >>> content_protect_rx_status_debug_test.sv
// self-checking bench of the status, key list and debug register slice
// assumes cprx_pkg and cprx_rx_model are compiled first
`default_nettype none

module content_protect_rx_status_debug_test;
  timeunit 1ns;
  timeprecision 1ps;
  import cprx_pkg::*;

  localparam int TO = 20;
  localparam logic [15:0] ROWS [13] = '{16'h801e, 16'h812d, 16'h823c,
    16'h834b, 16'h845a, 16'h92c3, 16'h93b4, 16'h94a5, 16'ha073,
    16'ha185, 16'ha20b, 16'hb000, 16'hc000};
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  cprx_reg_req_t req = '0;
  cprx_pixel_t pix = '0;
  cprx_rx_status_t rx_status;
  logic [39:0] rx_key;
  logic [7:0] rdata, list_byte, d;
  logic list_clear = 1'b0, activity = 1'b0, fs = 1'b0, push = 1'b0;
  logic repeater = 1'b1, key_ready = 1'b1, slow = 1'b1;
  logic [7:0] base = 8'h40;
  logic list_wr, bus_free, pj, ri, sync, cks_v, tmr, fast, ind;
  logic [23:0] cks;
  int n_errors = 0, compares = 0, fc = 0;

  cprx_status_debug #(.TIMEOUT_CYC(TO)) i_dut (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .reg_req_i(req), .reg_rdata_o(rdata),
    .tx_key_i(40'ha5b4c3d2e1), .rx_key_i(rx_key), .rx_status_i(rx_status),
    .key_list_clear_i(list_clear), .key_list_wr_i(list_wr),
    .key_list_byte_i(list_byte), .bus_activity_i(activity),
    .bus_free_o(bus_free), .frame_start_i(fs), .pj_check_o(pj),
    .ri_check_o(ri), .ri_sync_check_o(sync), .pixel_i(pix),
    .line_checksum_valid_o(cks_v), .line_checksum_o(cks),
    .auth_timer_accelerate_o(tmr), .bus_master_fast_timing_o(fast),
    .indirect_status_fast_o(ind));

  cprx_rx_model i_rx (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .repeater_i(repeater), .key_ready_i(key_ready), .push_i(push),
    .slow_i(slow), .base_i(base), .rx_status_o(rx_status),
    .rx_key_o(rx_key), .list_wr_o(list_wr), .list_byte_o(list_byte));

  // ==========================================================
  // shared tasks
  task automatic chk(string what, logic [23:0] seen, logic [23:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rd(logic [7:0] a, output logic [7:0] v);
    @(posedge clk_i);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    req.rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic rchk(logic [7:0] a, logic [7:0] exp);
    rd(a, d);
    chk($sformatf("reg %h", a), {16'h0000, d}, {16'h0000, exp});
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] v);
    @(posedge clk_i);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    req.wr <= 1'b0;
    #1;
  endtask

  task automatic pulse_push(logic [7:0] b);
    @(posedge clk_i);
    base <= b;
    push <= 1'b1;
    @(posedge clk_i);
    push <= 1'b0;
    repeat (10) @(posedge clk_i);
  endtask

  task automatic frame(logic test, logic nosync);
    int p_ri;
    int p_pj;
    p_ri = test ? 16 : 128;
    p_pj = test ? 2 : 16;
    @(posedge clk_i);
    fs <= 1'b1;
    @(posedge clk_i);
    fs <= 1'b0;
    fc = (fc + 1) % 128;
    #1;
    chk("pj", 24'(pj), 24'(fc % p_pj == 0));
    chk("ri", 24'(ri), 24'(fc % p_ri == 0));
    chk("sync", 24'(sync), 24'(!nosync && fc % p_ri == p_ri - 1));
  endtask

  task automatic close_out();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================================
  // clock and watchdog
  initial
  begin
    forever #2 clk_i = ~clk_i;
  end

  initial
  begin
    #200us;
    n_errors++;
    close_out();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (11) @(posedge clk_i);
    chk("reset outs", {8'h00, rdata, bus_free, pj, ri, sync, cks_v, tmr,
      fast, ind}, 24'h000000);
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    foreach (ROWS[i])
      rchk(ROWS[i][15:8], ROWS[i][7:0]);
    wr(8'h92, 8'h00);
    rchk(8'h92, 8'hc3);
    wr(8'hc0, 8'hff);
    chk("dbg outs", {21'h0, tmr, fast, ind}, 24'h7);
    rchk(8'hc0, 8'h5f);
    wr(8'hc0, 8'h00);
    chk("dbg outs", {21'h0, tmr, fast, ind}, 24'h0);
    @(posedge clk_i);
    repeater <= 1'b0;
    rchk(8'ha0, 8'h33);
    rchk(8'ha1, 8'h80);
    @(posedge clk_i);
    repeater <= 1'b1;
    key_ready <= 1'b0;
    rchk(8'ha0, 8'h33);
    @(posedge clk_i);
    key_ready <= 1'b1;
    pulse_push(8'h40);
    for (int k = 0; k < 3; k++)
      rchk(8'ha3, 8'h40 + 8'(k));
    rchk(8'ha3, 8'h00);
    slow <= 1'b0;
    pulse_push(8'h60);
    rchk(8'ha3, 8'h60);
    @(posedge clk_i);
    list_clear <= 1'b1;
    @(posedge clk_i);
    list_clear <= 1'b0;
    rchk(8'ha3, 8'h00);
    wr(8'hc0, 8'h04);
    repeat (32) frame(1'b1, 1'b0);
    wr(8'hc0, 8'h14);
    repeat (16) frame(1'b1, 1'b1);
    wr(8'hc0, 8'h00);
    repeat (128) frame(1'b0, 1'b0);
    @(posedge clk_i);
    activity <= 1'b1;
    @(posedge clk_i);
    activity <= 1'b0;
    repeat (TO) @(posedge clk_i);
    #1 chk("bus free", 24'(bus_free), 24'h0);
    @(posedge clk_i);
    #1 chk("bus free", 24'(bus_free), 24'h1);
    wr(8'hc0, 8'h40);
    repeat (2 * TO) @(posedge clk_i);
    #1 chk("bus free", 24'(bus_free), 24'h0);
    wr(8'hc0, 8'h08);
    @(posedge clk_i);
    pix <= '{valid: 1'b1, end_of_line: 1'b0, data: 24'hff8001};
    @(posedge clk_i);
    pix <= '{valid: 1'b1, end_of_line: 1'b1, data: 24'h029010};
    @(posedge clk_i);
    pix <= '0;
    #1 chk("cks valid", 24'(cks_v), 24'h1);
    chk("cks", cks, 24'hfdeeee);
    wr(8'hc0, 8'h00);
    @(posedge clk_i);
    pix <= '{valid: 1'b1, end_of_line: 1'b1, data: 24'h010203};
    @(posedge clk_i);
    pix <= '0;
    #1 chk("cks valid", 24'(cks_v), 24'h0);
    close_out();
  end
endmodule

`default_nettype wire
